/* File: design/scs_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module scs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  scs_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  always_comb begin
    push = port.wr_valid && port.wr_ready;
    pop = port.rd_valid && port.rd_ready;
    wp_d = push ? ((wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1) : wp_q;
    rp_d = pop ? ((rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end
  assign port.wr_ready = cnt_q != (AW+1)'(DEPTH);
  assign port.rd_valid = cnt_q != '0;
  assign port.rd_data = mem[rp_q];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= port.wr_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

/* File: design/scs_fifo_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface scs_fifo_if #(
  parameter int WIDTH = 16
);
  logic [WIDTH-1:0] wr_data;
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] rd_data;
  logic rd_valid;
  logic rd_ready;
  modport fifo (
    input wr_data,
    input wr_valid,
    output wr_ready,
    output rd_data,
    output rd_valid,
    input rd_ready
  );
  modport user (
    output wr_data,
    output wr_valid,
    input wr_ready,
    input rd_data,
    input rd_valid,
    output rd_ready
  );
endinterface
`default_nettype wire

/* File: design/scs_map.svh */
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH
`define SCS_CLK_PERIOD_NS 50
`define SCS_STOP_MODE_LATE 2'h2
`define SCS_STOP_MODE_EARLY 2'h3
`define SCS_POL_ACTIVE_LOW 1'h1
`define SCS_SLAVE_DIVIDE 8'h01
`define SCS_SLAVE_SRC_SEL 1'h1
`define SCS_WORD_BITS 16
`define SCS_FIFO_DEPTH 32
`define SCS_DIV_RST 8'h01
`endif

/* File: design/scs_pkg.sv */
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_IDLE,
    SCS_LEAD,
    SCS_SHIFT,
    SCS_TRAIL
  } scs_state_e;
  typedef logic [7:0] scs_div_t;
endpackage

/* File: design/scs_spi_port.sv */
// How it works
// R1: as master the bit clock period is (1 + divide value) times two processor half periods; the code gives two processor clocks for divide 0.
// R2: the low phase is half the period for odd or zero divide, else divide/2 units.
// R3: the high phase is half the period for odd or zero divide, else divide/2 + 1 units.
// R4: as master with both frame polarities at 1 the slave enable pin is driven active low.
// R5: as slave the active-low enable on both frame pins is inverted before internal use.
// R6: as master the transmit clock and frame are outputs, receive clock and frame inputs.
// R7: as slave all four clock and frame directions are 0, so every such pin is an input.
// R8: as slave the sample clock runs at half the processor clock, source select and divide 1.
// R9: the master asserts slave enable before the first rising edge, transfer starts there.
// R10: mode 10b with polarity 1 captures on the rising edge and drives after the falling edge.
// R11: mode 11b with polarity 1 captures on the falling edge and drives after the rising edge.
// R12: as master the first edge comes one high phase after enable in 10b, one period in 11b.
// R13: as master enable holds one period after the last edge in 10b, one high phase in 11b.
// R14: as slave the first bit is driven after enable, output released when enable goes away.
// R15: as master the data output goes high impedance after the last bit, from the last edge in 11b, as enable drops in 10b.
`timescale 1ns/10ps
`default_nettype none
`include "scs_map.svh"
module scs_spi_port #(
  parameter int WORD_BITS = `SCS_WORD_BITS,
  parameter int FIFO_DEPTH = `SCS_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic master_mode,
  input wire logic [1:0] clock_stop_mode,
  input wire logic tx_clock_polarity,
  input wire logic tx_frame_polarity,
  input wire logic rx_frame_polarity,
  input wire logic [7:0] clock_divide_value,
  input wire logic [WORD_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [WORD_BITS-1:0] rx_data,
  output logic rx_valid,
  output logic busy,
  output logic divider_source_select,
  output logic [7:0] divider_value_used,
  output logic tx_clock_direction,
  output logic rx_clock_direction,
  output logic tx_frame_direction,
  output logic rx_frame_direction,
  input wire logic serial_bit_clock_pin_i,
  output logic serial_bit_clock_pin_o,
  output logic serial_bit_clock_pin_oe,
  input wire logic slave_enable_pin_i,
  output logic slave_enable_pin_o,
  output logic slave_enable_pin_oe,
  input wire logic rx_frame_pin_i,
  input wire logic serial_in_pin,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe
);
  localparam int CW = $clog2(WORD_BITS + 1);
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // pin synchronisers, two flops before any use
  logic [2:0] pin_s1_q, pin_s2_q;
  // slave data in is foreign timing; master data in moves on this clock, read raw
  logic [1:0] din_s_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
      din_s_q <= 2'h0;
    end else begin
      pin_s1_q <= {serial_bit_clock_pin_i, slave_enable_pin_i, rx_frame_pin_i};
      pin_s2_q <= pin_s1_q;
      din_s_q <= {din_s_q[0], serial_in_pin};
    end
  end

  scs_fifo_if #(.WIDTH(WORD_BITS)) txf ();
  scs_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_txfifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .port(txf)
  );
  assign txf.wr_data = tx_data;
  assign txf.wr_valid = tx_valid;

  // state
  scs_pkg::scs_state_e st_q, st_d;
  logic [8:0] ph_q, ph_d;
  logic [CW-1:0] bit_q, bit_d;
  logic [WORD_BITS-1:0] sh_q, sh_d, rx_q, rx_d;
  logic sck_q, sck_d, en_q, en_d, dout_q, dout_d, doe_q, doe_d;
  logic rxv_q, rxv_d, txr_q, pop;
  logic sclk_prev_q, sclk_prev_d;
  logic early;
  logic [7:0] lo_len, hi_len;
  logic [8:0] per_len;
  logic sl_en, sl_clk, sl_rise, sl_fall, sl_cap, sl_drv, m_half_end;

  always_comb begin
    early = clock_stop_mode == `SCS_STOP_MODE_EARLY;
    // phases counted in processor clocks, one clock being 2P
    per_len = 9'(clock_divide_value) + 9'h001; // [R1]
    if (clock_divide_value[0] || clock_divide_value == 8'h00) begin
      // odd divide: exact halves; zero gives one clock, held as one per phase
      lo_len = (clock_divide_value == 8'h00) ? 8'h01 : 8'(per_len >> 1); // [R2]
      hi_len = (clock_divide_value == 8'h00) ? 8'h01 : 8'(per_len >> 1); // [R3]
    end else begin
      lo_len = clock_divide_value >> 1; // [R2]
      hi_len = (clock_divide_value >> 1) + 8'h01; // [R3]
    end
    sl_en = !pin_s2_q[1] && !pin_s2_q[0]; // [R5]
    sl_clk = pin_s2_q[2];
    sl_rise = sl_clk && !sclk_prev_q;
    sl_fall = !sl_clk && sclk_prev_q;
    sl_cap = early ? sl_fall : sl_rise; // [R10] [R11]
    sl_drv = early ? sl_rise : sl_fall; // [R10] [R11]
    m_half_end = ph_q == 9'h001;
  end

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rx_d = rx_q;
    sck_d = sck_q;
    en_d = en_q;
    dout_d = dout_q;
    doe_d = doe_q;
    rxv_d = 1'b0;
    pop = 1'b0;
    sclk_prev_d = sl_clk;
    if (master_mode) begin
      case (st_q)
        scs_pkg::SCS_IDLE: begin
          sck_d = tx_clock_polarity;
          doe_d = 1'b0; // [R15]
          if (txf.rd_valid) begin
            pop = 1'b1;
            en_d = 1'b1; // [R9]
            sh_d = txf.rd_data;
            dout_d = txf.rd_data[WORD_BITS-1];
            doe_d = 1'b1;
            bit_d = CW'(WORD_BITS);
            ph_d = early ? per_len : {1'b0, hi_len}; // [R12]
            st_d = scs_pkg::SCS_LEAD;
          end
        end
        scs_pkg::SCS_LEAD: begin
          ph_d = ph_q - 9'h001;
          if (m_half_end) begin
            sck_d = !tx_clock_polarity;
            ph_d = {1'b0, lo_len};
            st_d = scs_pkg::SCS_SHIFT;
            if (early) begin
              rx_d = {rx_q[WORD_BITS-2:0], serial_in_pin}; // [R11]
            end
          end
        end
        scs_pkg::SCS_SHIFT: begin
          ph_d = ph_q - 9'h001;
          if (m_half_end) begin
            sck_d = !sck_q;
            ph_d = (sck_q == tx_clock_polarity) ? {1'b0, lo_len} : {1'b0, hi_len};
            if (sck_q != tx_clock_polarity) begin
              // returning to idle level ends one bit
              bit_d = bit_q - CW'(1);
              // sampled a clock ahead of the pin, so phases of one clock fall short
              if (!early) begin
                rx_d = {rx_q[WORD_BITS-2:0], serial_in_pin}; // [R10]
              end
              if (bit_q == CW'(1)) begin
                ph_d = early ? {1'b0, hi_len} : per_len; // [R13]
                st_d = scs_pkg::SCS_TRAIL;
                doe_d = !early ? doe_q : 1'b0; // [R15]
              end else if (early) begin
                sh_d = {sh_q[WORD_BITS-2:0], 1'b0};
                dout_d = sh_q[WORD_BITS-2]; // [R11]
              end
            end else if (early) begin
              rx_d = {rx_q[WORD_BITS-2:0], serial_in_pin}; // [R11]
            end else begin
              // first bit stands from enable, later ones move after the fall
              sh_d = {sh_q[WORD_BITS-2:0], 1'b0};
              dout_d = sh_q[WORD_BITS-2]; // [R10]
            end
          end
        end
        scs_pkg::SCS_TRAIL: begin
          ph_d = ph_q - 9'h001;
          if (m_half_end) begin
            en_d = 1'b0; // [R13]
            doe_d = 1'b0; // [R15]
            rxv_d = 1'b1;
            st_d = scs_pkg::SCS_IDLE;
          end
        end
        default: st_d = scs_pkg::SCS_IDLE;
      endcase
    end else begin
      en_d = 1'b0;
      st_d = scs_pkg::SCS_IDLE;
      if (!sl_en) begin
        doe_d = 1'b0; // [R14]
        if (bit_q != '0 && bit_q != CW'(WORD_BITS)) begin
          rxv_d = 1'b0;
        end
        bit_d = '0;
      end else begin
        if (!doe_q && bit_q == '0) begin
          pop = txf.rd_valid;
          sh_d = txf.rd_valid ? txf.rd_data : '0;
          dout_d = txf.rd_valid ? txf.rd_data[WORD_BITS-1] : 1'b0; // [R14]
          doe_d = 1'b1; // [R14]
        end
        if (sl_cap && bit_q != CW'(WORD_BITS)) begin
          rx_d = {rx_q[WORD_BITS-2:0], din_s_q[1]};
          bit_d = bit_q + CW'(1);
          rxv_d = bit_q == CW'(WORD_BITS - 1);
        end
        if (sl_drv && bit_q != '0) begin
          sh_d = {sh_q[WORD_BITS-2:0], 1'b0};
          dout_d = sh_q[WORD_BITS-2];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= scs_pkg::SCS_IDLE;
      ph_q <= 9'h000;
      bit_q <= '0;
      sh_q <= '0;
      rx_q <= '0;
      sck_q <= 1'b1;
      en_q <= 1'b0;
      dout_q <= 1'b0;
      doe_q <= 1'b0;
      rxv_q <= 1'b0;
      sclk_prev_q <= 1'b1;
      txr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      sck_q <= sck_d;
      en_q <= en_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      rxv_q <= rxv_d;
      sclk_prev_q <= sclk_prev_d;
      txr_q <= txf.wr_ready;
    end
  end
  // ready is registered a cycle behind the fifo; a write into a full fifo is dropped
  assign txf.rd_ready = pop;

  // pin directions and outputs, all from flops
  logic [14:0] out_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 15'h0000;
    end else begin
      out_q <= {master_mode, master_mode, // [R6] [R7]
                sck_q, master_mode,
                (tx_frame_polarity == `SCS_POL_ACTIVE_LOW) ? !en_q : en_q, // [R4]
                master_mode,
                master_mode ? 1'b0 : `SCS_SLAVE_SRC_SEL, // [R8]
                dout_q, doe_q, rxv_q, st_q != scs_pkg::SCS_IDLE || sl_en,
                rx_frame_polarity, 3'h0};
    end
  end
  assign tx_clock_direction = out_q[14];
  assign tx_frame_direction = out_q[13];
  assign rx_clock_direction = out_q[2]; // [R6] [R7]
  assign rx_frame_direction = out_q[1];
  assign serial_bit_clock_pin_o = out_q[12];
  assign serial_bit_clock_pin_oe = out_q[11];
  assign slave_enable_pin_o = out_q[10];
  assign slave_enable_pin_oe = out_q[9];
  assign divider_source_select = out_q[8];
  assign serial_out_pin_o = out_q[7];
  assign serial_out_pin_oe = out_q[6];
  assign rx_valid = out_q[5];
  assign busy = out_q[4];
  assign tx_ready = txr_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data <= '0;
      divider_value_used <= `SCS_DIV_RST;
    end else begin
      if (rxv_q) begin
        rx_data <= rx_q;
      end
      divider_value_used <= master_mode ? clock_divide_value : `SCS_SLAVE_DIVIDE; // [R8]
    end
  end
endmodule
`default_nettype wire

/* File: test/scs_spi_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scs_map.svh"
module scs_spi_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic master_mode,
  input wire logic [1:0] clock_stop_mode,
  input wire logic [7:0] clock_divide_value,
  input wire logic divider_source_select,
  input wire logic [7:0] divider_value_used,
  input wire logic tx_clock_direction,
  input wire logic rx_clock_direction,
  input wire logic tx_frame_direction,
  input wire logic rx_frame_direction,
  input wire logic serial_bit_clock_pin_o,
  input wire logic serial_bit_clock_pin_oe,
  input wire logic slave_enable_pin_i,
  input wire logic slave_enable_pin_o,
  input wire logic slave_enable_pin_oe,
  input wire logic serial_out_pin_oe
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  logic [2:0] up_q, up_d;
  logic [8:0] run_q, run_d, per, lo, hi;
  logic ck_q, ck_d, en_q, en_d, fst_q, fst_d, ok, slv, m11;
  always_comb begin
    per = {1'b0, clock_divide_value} + 9'h001;
    lo = per >> 1;
    hi = clock_divide_value[0] ? lo : lo + 9'h001;
    m11 = clock_stop_mode == `SCS_STOP_MODE_EARLY;
    ok = up_q == 3'h7 && master_mode;
    slv = up_q == 3'h7 && !master_mode;
    up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
    // undriven pins read as pulled high, so role changes do not look like edges
    ck_d = !serial_bit_clock_pin_oe | serial_bit_clock_pin_o;
    en_d = !slave_enable_pin_oe | slave_enable_pin_o;
    run_d = (ck_d != ck_q || en_d != en_q) ? 9'h001 : run_q + 9'h001;
    fst_d = (en_q && !en_d) || (fst_q && !(ck_q && !ck_d));
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      up_q <= 3'h0;
      run_q <= 9'h000;
      ck_q <= 1'b1;
      en_q <= 1'b1;
      fst_q <= 1'b0;
    end else begin
      up_q <= up_d;
      run_q <= run_d;
      ck_q <= ck_d;
      en_q <= en_d;
      fst_q <= fst_d;
    end
  end
  property p_low;
    ok && !ck_q && ck_d && !en_d |-> run_q == lo;
  endproperty
  a_low: assert property (p_low) else $error("low phase length");
  property p_high;
    ok && $fell(ck_d) && !fst_q |-> run_q == hi;
  endproperty
  a_high: assert property (p_high) else $error("high phase length");
  property p_first;
    ok && $fell(ck_d) && fst_q |-> run_q == (m11 ? per : hi);
  endproperty
  a_first: assert property (p_first) else $error("first edge timing");
  property p_hold;
    ok && $rose(en_d) |-> run_q == (m11 ? hi : per);
  endproperty
  a_hold: assert property (p_hold) else $error("enable hold timing");
  property p_oe_end;
    ok && $rose(en_d) |-> !serial_out_pin_oe;
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("data not released");
  property p_tx_dir;
    ok && $past(master_mode) |-> tx_clock_direction && tx_frame_direction;
  endproperty
  a_tx_dir: assert property (p_tx_dir) else $error("master directions");
  property p_rx_dir;
    up_q == 3'h7 |-> !rx_clock_direction && !rx_frame_direction;
  endproperty
  a_rx_dir: assert property (p_rx_dir) else $error("receive directions");
  property p_slave;
    slv && !$past(master_mode) |-> !tx_clock_direction && !tx_frame_direction &&
      divider_source_select && divider_value_used == `SCS_SLAVE_DIVIDE;
  endproperty
  a_slave: assert property (p_slave) else $error("slave setup");
  property p_slv_on;
    slv && $fell(slave_enable_pin_i) |-> ##[1:6] serial_out_pin_oe;
  endproperty
  a_slv_on: assert property (p_slv_on) else $error("slave output late");
  property p_slv_off;
    slv && $rose(slave_enable_pin_i) |-> ##[1:6] !serial_out_pin_oe;
  endproperty
  a_slv_off: assert property (p_slv_off) else $error("slave output held");
  c_late: cover property (ok && $fell(en_d) && !m11);
  c_early: cover property (ok && $fell(en_d) && m11);
  c_slave: cover property (slv && $fell(slave_enable_pin_i));
endmodule
bind scs_spi_port scs_spi_monitor mon_u (
  .ref_clk, .resetn, .master_mode, .clock_stop_mode, .clock_divide_value,
  .divider_source_select, .divider_value_used, .tx_clock_direction, .rx_clock_direction,
  .tx_frame_direction, .rx_frame_direction, .serial_bit_clock_pin_o, .serial_bit_clock_pin_oe,
  .slave_enable_pin_i, .slave_enable_pin_o, .slave_enable_pin_oe, .serial_out_pin_oe
);
`default_nettype wire

/* File: test/scs_spi_peer.sv */
`timescale 1ns/10ps
`default_nettype none
module scs_spi_peer (
  input wire logic mode11,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic mosi_oe,
  input wire logic [15:0] word_out,
  output logic miso,
  output logic [15:0] word_in,
  output logic lost
);
  logic [15:0] sh;
  int n;
  initial begin
    miso = 1'b0;
    word_in = 16'h0000;
    lost = 1'b0;
  end
  always @(negedge ss_n) begin
    sh = word_out;
    miso = sh[15];
    n = 0;
    lost = 1'b0;
  end
  // released line has no pull, so show the inverse of the last bit
  always @(posedge ss_n) miso = ~miso;
  always @(sck) begin
    if (!ss_n && sck != mode11) begin
      word_in = {word_in[14:0], mosi};
      lost = lost | !mosi_oe;
    end else if (!ss_n) begin
      n++;
      if (mode11 || n > 1) begin
        sh = sh << 1;
        miso = sh[15];
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scs_map.svh"
module testbench;
  logic ref_clk, resetn, master_mode, tx_valid, sck_i, en_i, mosi_tb;
  logic tx_ready, rx_valid, busy, dss, tcd, rcd, tfd, rfd;
  logic sck_o, sck_oe, en_o, en_oe, sout, sout_oe, pmiso, lost;
  logic [1:0] mode;
  logic [7:0] div, dvu;
  logic [15:0] tx_data, rx_data, peer_out, peer_in, cap;
  int mismatches, checks_done, exp_n, pushed;
  int seen = 0;
  scs_spi_port dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .master_mode(master_mode), .clock_stop_mode(mode),
    .tx_clock_polarity(1'b1), .tx_frame_polarity(1'b1), .rx_frame_polarity(1'b1),
    .clock_divide_value(div), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy), .divider_source_select(dss),
    .divider_value_used(dvu), .tx_clock_direction(tcd), .rx_clock_direction(rcd),
    .tx_frame_direction(tfd), .rx_frame_direction(rfd), .serial_bit_clock_pin_i(sck_i),
    .serial_bit_clock_pin_o(sck_o), .serial_bit_clock_pin_oe(sck_oe),
    .slave_enable_pin_i(en_i), .slave_enable_pin_o(en_o), .slave_enable_pin_oe(en_oe),
    .rx_frame_pin_i(en_i), .serial_in_pin(master_mode ? pmiso : mosi_tb),
    .serial_out_pin_o(sout), .serial_out_pin_oe(sout_oe)
  );
  scs_spi_peer peer_u (
    .mode11(mode[0]), .sck(!sck_oe | sck_o), .ss_n(!en_oe | en_o), .mosi(sout),
    .mosi_oe(sout_oe), .word_out(peer_out), .miso(pmiso), .word_in(peer_in), .lost(lost)
  );
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) seen <= seen + 1;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ready lags a cycle, so leave one idle cycle after each push
  task automatic push(input logic [15:0] w);
    for (int i = 0; i < 400 && tx_ready !== 1'b1; i++) tick(1);
    chk("tx_ready", 16'h0001, {15'h0000, tx_ready});
    tx_data = w;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
    tick(1);
  endtask
  task automatic wait_rx;
    exp_n++;
    for (int i = 0; i < 4000 && seen < exp_n; i++) tick(1);
    chk("frames", exp_n[15:0], seen[15:0]);
  endtask
  task automatic master_frame(input logic [1:0] m, input logic [7:0] d,
                              input logic [15:0] w, input logic [15:0] p);
    mode = m;
    div = d;
    peer_out = p;
    master_mode = 1'b1;
    tick(2);
    chk("tx_dirs", 16'h0033, {10'h000, tcd, tfd, rcd, rfd, sck_oe, en_oe});
    push(w);
    tick(2);
    chk("busy", 16'h0001, {15'h0000, busy});
    wait_rx;
    chk("rx_data", p, rx_data);
    chk("peer_in", w, peer_in);
    chk("out_oe", 16'h0000, {14'h0000, busy, lost});
  endtask
  task automatic slave_frame(input logic [1:0] m, input logic [15:0] mw, input logic [15:0] sw);
    logic bad;
    bad = 1'b0;
    mode = m;
    master_mode = 1'b0;
    tick(3);
    chk("slv_dirs", 16'h0000, {10'h000, tcd, tfd, rcd, rfd, sck_oe, en_oe});
    chk("slv_div", 16'h0101, {7'h00, dss, dvu});
    push(sw);
    tick(2);
    en_i = 1'b0;
    mosi_tb = mw[15];
    tick(6);
    for (int i = 0; i < 16; i++) begin
      sck_i = 1'b0;
      bad = bad | !sout_oe;
      if (m[0]) cap = {cap[14:0], sout};
      else if (i > 0) mosi_tb = mw[15 - i];
      tick(6);
      sck_i = 1'b1;
      if (!m[0]) cap = {cap[14:0], sout};
      else if (i < 15) mosi_tb = mw[14 - i];
      tick(6);
    end
    en_i = 1'b1;
    mosi_tb = ~mosi_tb;
    wait_rx;
    chk("slv_rx", mw, rx_data);
    chk("slv_tx", sw, cap);
    chk("slv_oe_on", 16'h0000, {15'h0000, bad});
    tick(6);
    chk("slv_oe_off", 16'h0000, {15'h0000, sout_oe});
  endtask
  initial begin
    mismatches = 0;
    checks_done = 0;
    exp_n = 0;
    resetn = 1'b0;
    master_mode = 1'b1;
    mode = 2'h2;
    div = 8'h03;
    tx_data = 16'h0000;
    tx_valid = 1'b0;
    sck_i = 1'b1;
    en_i = 1'b1;
    mosi_tb = 1'b0;
    peer_out = 16'h0000;
    tick(3);
    resetn = 1'b1;
    tick(3);
    for (int k = 0; k < 4; k++) begin
      master_frame({1'b1, k[0]}, 8'h03 + {7'h00, k[1]}, {14'h30E9, k[1:0]}, {k[1:0], 14'h1A5C});
    end
    peer_out = 16'hA55A;
    for (pushed = 0; pushed < 40 && tx_ready === 1'b1; pushed++) push(pushed[15:0]);
    chk("full", 16'h0001, {15'h0000, pushed >= `SCS_FIFO_DEPTH && tx_ready === 1'b0});
    exp_n = exp_n + pushed - 1;
    wait_rx;
    tick(200);
    chk("no_extra", exp_n[15:0], seen[15:0]);
    chk("last_word", pushed[15:0] - 16'h0001, peer_in);
    chk("rx_data", 16'hA55A, rx_data);
    slave_frame(2'h2, 16'h9A6E, 16'h61F2);
    slave_frame(2'h3, 16'h4C1B, 16'hE38D);
    results;
  end
  initial begin
    #(20000 * `SCS_CLK_PERIOD_NS);
    mismatches++;
    results;
  end
endmodule
`default_nettype wire
